// >>> rtl/exec_pkg.sv
// Package: constants, types and decode helpers for the instruction execution block
package exec_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_INSTR   = 16'h0000;
  localparam logic [15:0] OFF_ACCUM   = 16'h0004;
  localparam logic [15:0] OFF_STATUS  = 16'h0008;
  localparam logic [15:0] OFF_BANK    = 16'h000C;
  localparam logic [15:0] OFF_CTRL    = 16'h0010;
  localparam logic [15:0] OFF_INDEX   = 16'h0014;
  localparam logic [15:0] OFF_EXSTAT  = 16'h0018;
  localparam logic [15:0] OFF_MEM     = 16'h1000;
  localparam logic [15:0] MEM_SPAN    = 16'h1000;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int          INSTR_TWO_WORD_BIT = 16;
  localparam int          ST_C_BIT           = 0;
  localparam int          ST_Z_BIT           = 2;
  localparam int          ST_N_BIT           = 4;
  localparam int          CTRL_EXT_BIT       = 0;
  localparam int          EX_BUSY_BIT        = 0;
  localparam int          EX_NOPS_LSB        = 4;
  localparam int          EX_LASTCYC_LSB     = 8;
  localparam int          BANK_W             = 2;
  localparam int          ADDR_W             = 10;
  localparam int          MEM_DEPTH          = 1024;

  // ----------------------------------------------------------------
  // Reset values and addressing constants
  // ----------------------------------------------------------------
  localparam logic [7:0]        ACCUM_RST     = 8'h00;
  localparam logic [7:0]        STATUS_RST    = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST      = 2'h0;
  localparam logic [ADDR_W-1:0] INDEX_RST     = 10'h000;
  localparam logic [7:0]        ACCESS_SPLIT  = 8'h80;
  localparam logic [7:0]        INDEXED_MAX   = 8'h5F;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 2'h3;
  localparam logic [1:0]        NOPS_ONE_WORD = 2'h1;
  localparam logic [1:0]        NOPS_TWO_WORD = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_NOP = 2'b00,
    KIND_RLC = 2'b01,
    KIND_TST = 2'b10,
    KIND_XOR = 2'b11
  } kind_t;

  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;

  // Opcode prefixes: rotate 0011 01, test 0110 011, xor literal 0000 1010
  function automatic kind_t decode_kind(input logic [15:0] ins);
    if (ins[15:10] == 6'h0D) begin
      return KIND_RLC;
    end else if (ins[15:9] == 7'h33) begin
      return KIND_TST;
    end else if (ins[15:8] == 8'h0A) begin
      return KIND_XOR;
    end
    return KIND_NOP;
  endfunction

endpackage

// >>> rtl/alu_if.sv
// Interface: operands and results between the sequencer and the datapath
`timescale 1ns/1ps
interface alu_if;
  exec_pkg::kind_t kind;
  logic [7:0]      operand;
  logic [7:0]      accum;
  logic [7:0]      literal;
  logic            carry_in;
  logic [7:0]      result;
  logic            carry_out;
  logic            neg;
  logic            zero;

  modport seq (output kind, operand, accum, literal, carry_in,
               input  result, carry_out, neg, zero);
  modport alu (input  kind, operand, accum, literal, carry_in,
               output result, carry_out, neg, zero);
endinterface

// >>> rtl/exec_alu.sv
// Datapath: rotate through carry, literal xor, zero test and flag results
`timescale 1ns/1ps
module exec_alu (
  alu_if.alu a
);

  always_comb begin
    a.carry_out = a.carry_in;
    unique case (a.kind)
      exec_pkg::KIND_RLC: begin
        a.result    = {a.operand[6:0], a.carry_in};
        a.carry_out = a.operand[7];
      end
      exec_pkg::KIND_XOR: a.result = a.accum ^ a.literal;
      exec_pkg::KIND_TST: a.result = a.operand;
      exec_pkg::KIND_NOP: a.result = a.accum;
    endcase
    a.neg  = a.result[7];
    a.zero = (a.result == 8'h00);
  end

endmodule

// >>> rtl/rotate_test_xor_exec.sv
// Top: AHB-Lite register slave and four-phase sequencer for three instructions
`timescale 1ns/1ps
module rotate_test_xor_exec (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                          dp_valid;
    logic                          dp_write;
    logic [15:0]                   dp_addr;
    logic [31:0]                   rdata;
    logic                          ready;
    logic                          resp;
    logic [7:0]                    accum;
    logic [7:0]                    status;
    logic [exec_pkg::BANK_W-1:0]   bank;
    logic                          ext_en;
    logic [exec_pkg::ADDR_W-1:0]   index;
    logic [16:0]                   ir;
    logic                          active;
    exec_pkg::phase_t              phase;
    exec_pkg::kind_t               kind;
    logic [exec_pkg::ADDR_W-1:0]   faddr;
    logic [7:0]                    opnd;
    logic [7:0]                    res;
    logic                          c_res;
    logic                          n_res;
    logic                          z_res;
    logic [1:0]                    nops;
    logic [1:0]                    cycles;
    logic [1:0]                    last_cycles;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [7:0]                  mem [exec_pkg::MEM_DEPTH];
  logic                        mem_we;
  logic [exec_pkg::ADDR_W-1:0] mem_wa;
  logic [7:0]                  mem_wd;

  alu_if alu_bus ();

  exec_alu u_alu (
    .a (alu_bus.alu)
  );

  assign hrdata    = s_r.rdata;
  assign hreadyout = s_r.ready;
  assign hresp     = s_r.resp;

  // ----------------------------------------------------------------
  // Operand address formation
  // ----------------------------------------------------------------
  function automatic logic [exec_pkg::ADDR_W-1:0] file_addr(
    input logic [7:0]                  f,
    input logic                        a_bit,
    input logic                        ext,
    input logic [exec_pkg::BANK_W-1:0] bank,
    input logic [exec_pkg::ADDR_W-1:0] index
  );
    if (a_bit) begin
      return {bank, f};
    end else if (ext && (f <= exec_pkg::INDEXED_MAX)) begin
      return exec_pkg::ADDR_W'(index + {2'b00, f});
    end else if (f < exec_pkg::ACCESS_SPLIT) begin
      return {{exec_pkg::BANK_W{1'b0}}, f};
    end
    return {exec_pkg::ACCESS_HI_BANK, f};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] off;
    logic [15:0] moff;
    s_nxt  = s_r;
    mem_we = 1'b0;
    mem_wa = s_r.faddr;
    mem_wd = s_r.res;
    off    = s_r.dp_addr;
    moff   = 16'(s_r.dp_addr - exec_pkg::OFF_MEM);

    alu_bus.kind     = s_r.kind;
    alu_bus.operand  = s_r.opnd;
    alu_bus.accum    = s_r.accum;
    alu_bus.literal  = s_r.ir[7:0];
    alu_bus.carry_in = s_r.status[exec_pkg::ST_C_BIT];

    // Bus: accept address phase, then finish once the core is idle
    if (s_r.dp_valid) begin
      if (!s_r.active) begin
        s_nxt.dp_valid = 1'b0;
        s_nxt.ready    = 1'b1;
        s_nxt.rdata    = 32'h0000_0000;
        if (s_r.dp_write) begin
          if (off == exec_pkg::OFF_INSTR) begin
            s_nxt.ir     = hwdata[16:0];
            s_nxt.active = 1'b1;
            s_nxt.phase  = exec_pkg::PH_DECODE;
            s_nxt.cycles = 2'h1;
          end else if (off == exec_pkg::OFF_ACCUM) begin
            s_nxt.accum = hwdata[7:0];
          end else if (off == exec_pkg::OFF_STATUS) begin
            s_nxt.status = hwdata[7:0];
          end else if (off == exec_pkg::OFF_BANK) begin
            s_nxt.bank = hwdata[exec_pkg::BANK_W-1:0];
          end else if (off == exec_pkg::OFF_CTRL) begin
            s_nxt.ext_en = hwdata[exec_pkg::CTRL_EXT_BIT];
          end else if (off == exec_pkg::OFF_INDEX) begin
            s_nxt.index = hwdata[exec_pkg::ADDR_W-1:0];
          end else if (off >= exec_pkg::OFF_MEM && moff < exec_pkg::MEM_SPAN) begin
            mem_we = 1'b1;
            mem_wa = moff[exec_pkg::ADDR_W+1:2];
            mem_wd = hwdata[7:0];
          end
        end else begin
          if (off == exec_pkg::OFF_INSTR) begin
            s_nxt.rdata = {15'h0000, s_r.ir};
          end else if (off == exec_pkg::OFF_ACCUM) begin
            s_nxt.rdata = {24'h000000, s_r.accum};
          end else if (off == exec_pkg::OFF_STATUS) begin
            s_nxt.rdata = {24'h000000, s_r.status};
          end else if (off == exec_pkg::OFF_BANK) begin
            s_nxt.rdata = {30'h00000000, s_r.bank};
          end else if (off == exec_pkg::OFF_CTRL) begin
            s_nxt.rdata = {31'h00000000, s_r.ext_en};
          end else if (off == exec_pkg::OFF_INDEX) begin
            s_nxt.rdata = {22'h000000, s_r.index};
          end else if (off == exec_pkg::OFF_EXSTAT) begin
            s_nxt.rdata = {22'h000000, s_r.last_cycles, 2'h0, s_r.nops, 3'h0, s_r.active};
          end else if (off >= exec_pkg::OFF_MEM && moff < exec_pkg::MEM_SPAN) begin
            s_nxt.rdata = {24'h000000, mem[moff[exec_pkg::ADDR_W+1:2]]};
          end
        end
      end
    end else if (hsel && htrans[1] && hready) begin
      s_nxt.dp_valid = 1'b1;
      s_nxt.dp_write = hwrite;
      s_nxt.dp_addr  = haddr[15:0];
      s_nxt.ready    = 1'b0;
    end

    // Sequencer: one phase per clock, four phases per instruction cycle
    if (s_r.active) begin
      s_nxt.phase = exec_pkg::phase_t'(2'(s_r.phase + 2'h1));
      if (s_r.nops != 2'h0) begin
        // Flushed word: every phase is a no-operation
        if (s_r.phase == exec_pkg::PH_WRITE) begin
          s_nxt.nops   = 2'(s_r.nops - 2'h1);
          s_nxt.cycles = 2'(s_r.cycles + 2'h1);
          if (s_r.nops == 2'h1) begin
            s_nxt.active      = 1'b0;
            s_nxt.last_cycles = s_r.cycles;
          end
        end
      end else begin
        unique case (s_r.phase)
          exec_pkg::PH_DECODE: begin
            s_nxt.kind  = exec_pkg::decode_kind(s_r.ir[15:0]);
            s_nxt.faddr = file_addr(s_r.ir[7:0], s_r.ir[8], s_r.ext_en,
                                    s_r.bank, s_r.index);
          end
          exec_pkg::PH_READ: begin
            s_nxt.opnd = mem[s_r.faddr];
          end
          exec_pkg::PH_PROCESS: begin
            s_nxt.res   = alu_bus.result;
            s_nxt.c_res = alu_bus.carry_out;
            s_nxt.n_res = alu_bus.neg;
            s_nxt.z_res = alu_bus.zero;
          end
          exec_pkg::PH_WRITE: begin
            unique case (s_r.kind)
              exec_pkg::KIND_RLC: begin
                if (s_r.ir[9]) begin
                  mem_we = 1'b1;
                end else begin
                  s_nxt.accum = s_r.res;
                end
                s_nxt.status[exec_pkg::ST_C_BIT] = s_r.c_res;
                s_nxt.status[exec_pkg::ST_N_BIT] = s_r.n_res;
                s_nxt.status[exec_pkg::ST_Z_BIT] = s_r.z_res;
              end
              exec_pkg::KIND_XOR: begin
                s_nxt.accum = s_r.res;
                s_nxt.status[exec_pkg::ST_N_BIT] = s_r.n_res;
                s_nxt.status[exec_pkg::ST_Z_BIT] = s_r.z_res;
              end
              exec_pkg::KIND_TST: begin
                // Flags untouched; a zero operand flushes the next word(s)
                if (s_r.z_res) begin
                  s_nxt.nops = s_r.ir[exec_pkg::INSTR_TWO_WORD_BIT]
                             ? exec_pkg::NOPS_TWO_WORD
                             : exec_pkg::NOPS_ONE_WORD;
                end
              end
              exec_pkg::KIND_NOP: begin
              end
            endcase
            if (!(s_r.kind == exec_pkg::KIND_TST && s_r.z_res)) begin
              s_nxt.active      = 1'b0;
              s_nxt.last_cycles = s_r.cycles;
            end else begin
              s_nxt.cycles = 2'(s_r.cycles + 2'h1);
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r        <= '0;
      s_r.ready  <= 1'b1;
      s_r.accum  <= exec_pkg::ACCUM_RST;
      s_r.status <= exec_pkg::STATUS_RST;
      s_r.bank   <= exec_pkg::BANK_RST;
      s_r.index  <= exec_pkg::INDEX_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Data memory has no reset: contents are undefined until written
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

endmodule

// >>> tb/rotate_test_xor_exec_checker.sv
// Checker: handshake timing and shadowed instruction results at the top ports
`timescale 1ns/1ps
module rotate_test_xor_exec_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout
);
  logic        dp_r, wr_r, acc_ok_r, st_ok_r, ran_r, tst_r, two_r, iss_r;
  logic        tk, done, ins, rd_acc, rd_st, rd_ex;
  logic [15:0] adr_r;
  logic [7:0]  acc_r, xr;
  logic [2:0]  st_r;
  // ----------------------------------------------------------------
  // Shadows; a rotate makes the status shadow unknown, and the accumulator one when it targets the accumulator, until software rewrites them
  // ----------------------------------------------------------------
  assign tk     = hsel & htrans[1] & hready;
  assign done   = dp_r & hreadyout;
  assign ins    = done & wr_r & (adr_r == exec_pkg::OFF_INSTR);
  assign rd_acc = done & !wr_r & (adr_r == exec_pkg::OFF_ACCUM) & acc_ok_r;
  assign rd_st  = done & !wr_r & (adr_r == exec_pkg::OFF_STATUS) & st_ok_r;
  assign rd_ex  = done & !wr_r & (adr_r == exec_pkg::OFF_EXSTAT);
  assign xr     = acc_r ^ hwdata[7:0];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {dp_r, wr_r, ran_r, tst_r, two_r, iss_r} <= 6'h00;
      {acc_ok_r, st_ok_r} <= 2'h3;
      adr_r <= 16'h0000;
      acc_r <= 8'h00;
      st_r  <= 3'h0;
    end else begin
      iss_r <= ins & ((hwdata[15:10] == 6'h0D) | (hwdata[15:8] == 8'h0A));
      if (tk) begin
        dp_r  <= 1'h1;
        wr_r  <= hwrite;
        adr_r <= haddr[15:0];
      end else if (done) begin
        dp_r <= 1'h0;
      end
      if (done & wr_r & (adr_r == exec_pkg::OFF_ACCUM)) begin
        acc_r    <= hwdata[7:0];
        acc_ok_r <= 1'h1;
      end
      if (done & wr_r & (adr_r == exec_pkg::OFF_STATUS)) begin
        st_r    <= {hwdata[4], hwdata[2], hwdata[0]};
        st_ok_r <= 1'h1;
      end
      if (ins) begin
        ran_r <= 1'h1;
        tst_r <= (hwdata[15:9] == 7'h33);
        two_r <= hwdata[16];
      end
      if (ins & (hwdata[15:8] == 8'h0A)) begin
        acc_r <= xr;
        st_r  <= {xr[7], xr == 8'h00, st_r[0]};
      end
      if (ins & (hwdata[15:10] == 6'h0D)) begin
        st_ok_r  <= 1'h0;
        acc_ok_r <= acc_ok_r & hwdata[9];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_acc;
    rd_acc |-> hrdata == {24'h000000, acc_r};
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator read differs from shadow");
  property p_nz;
    rd_st |-> {hrdata[4], hrdata[2]} == st_r[2:1];
  endproperty
  a_nz: assert property (p_nz) else $error("negative or zero flag wrong");
  property p_carry;
    rd_st |-> hrdata[0] == st_r[0];
  endproperty
  a_carry: assert property (p_carry) else $error("carry changed unexpectedly");
  property p_busy;
    rd_ex |-> !hrdata[0];
  endproperty
  a_busy: assert property (p_busy) else $error("status read completed while busy");
  property p_one;
    rd_ex & ran_r & !tst_r |-> hrdata[9:8] == 2'h1;
  endproperty
  a_one: assert property (p_one) else $error("single cycle count wrong");
  property p_skip;
    rd_ex & tst_r |-> hrdata[9:8] == 2'h1 || hrdata[9:8] == (two_r ? 2'h3 : 2'h2);
  endproperty
  a_skip: assert property (p_skip) else $error("skip cycle count wrong");
  property p_stall;
    tk |=> !hreadyout ##[1:13] hreadyout;
  endproperty
  a_stall: assert property (p_stall) else $error("transfer not answered in time");
  property p_four;
    iss_r & tk |=> !hreadyout ##1 !hreadyout ##[1:3] hreadyout;
  endproperty
  a_four: assert property (p_four) else $error("four phase timing wrong");
endmodule

// >>> tb/rotate_test_xor_instruction_exec_tb.sv
// Testbench: bus tasks and instruction scenarios for the execution block
`timescale 1ns/1ps
module rotate_test_xor_instruction_exec_tb;
  localparam logic [31:0] A_INS = {16'h0000, exec_pkg::OFF_INSTR};
  localparam logic [31:0] A_ACC = {16'h0000, exec_pkg::OFF_ACCUM};
  localparam logic [31:0] A_ST  = {16'h0000, exec_pkg::OFF_STATUS};
  localparam logic [31:0] A_EX  = {16'h0000, exec_pkg::OFF_EXSTAT};
  logic        clk, rst_b, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          fail_count, num_checks;

  rotate_test_xor_exec u_dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
                              .hready(hreadyout), .hrdata, .hreadyout, .hresp);

  function automatic logic [31:0] ma(input logic [9:0] i);
    return 32'h0000_1000 + {20'h00000, i, 2'h0};
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A hung slave ends the run instead of stalling it
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 100);
    if (n >= 100) begin
      fail_count++;
      results();
    end
  endtask

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d);
  endtask

  // Every read also confirms the slave never answers with an error response
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'h0, 32'h0000_0000);
    check(rd, e);
    check({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {fail_count, num_checks} = 0;
    {rst_b, hsel, hwrite, htrans} = 5'h00;
    hsize  = 3'h2;
    haddr  = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    // ----------------------------------------------------------------
    // Reset state, read-only status word and unmapped word
    // ----------------------------------------------------------------
    wr(A_EX, 32'hFFFF_FFFF);
    wr(32'h0000_001C, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      rd_chk(32'(i * 4), 32'h0000_0000);
    end
    // ----------------------------------------------------------------
    // Literal xor chain: plain, zero and negative results, carry kept
    // ----------------------------------------------------------------
    wr(A_ST, 32'h0000_0001);
    wr(A_ACC, 32'h0000_00B5);
    wr(A_INS, 32'h0000_0AAF);
    rd_chk(A_ACC, 32'h0000_001A);
    rd_chk(A_ST, 32'h0000_0001);
    wr(A_INS, 32'h0000_0A1A);
    rd_chk(A_ST, 32'h0000_0005);
    wr(A_INS, 32'h0000_0A80);
    rd_chk(A_ACC, 32'h0000_0080);
    rd_chk(A_ST, 32'h0000_0011);
    rd_chk(A_EX, 32'h0000_0100);
    // ----------------------------------------------------------------
    // Rotates: banked to accumulator, access bank high half, indexed
    // ----------------------------------------------------------------
    wr(32'h0000_000C, 32'h0000_0002);
    wr(ma(10'h234), 32'h0000_00E6);
    wr(A_ST, 32'h0000_0000);
    wr(A_INS, 32'h0000_3534);
    rd_chk(A_ACC, 32'h0000_00CC);
    rd_chk(A_ST, 32'h0000_0011);
    rd_chk(ma(10'h234), 32'h0000_00E6);
    rd_chk(A_EX, 32'h0000_0100);
    wr(ma(10'h390), 32'h0000_0080);
    wr(A_ST, 32'h0000_0000);
    wr(A_INS, 32'h0000_3690);
    rd_chk(ma(10'h390), 32'h0000_0000);
    rd_chk(A_ST, 32'h0000_0005);
    rd_chk(A_ACC, 32'h0000_00CC);
    wr(32'h0000_0010, 32'h0000_0001);
    wr(32'h0000_0014, 32'h0000_0155);
    wr(ma(10'h1B4), 32'h0000_0001);
    wr(A_ST, 32'h0000_0001);
    wr(A_INS, 32'h0000_365F);
    rd_chk(ma(10'h1B4), 32'h0000_0003);
    rd_chk(A_ST, 32'h0000_0000);
    // ----------------------------------------------------------------
    // Test and skip: zero with one and two word flush, then nonzero
    // ----------------------------------------------------------------
    wr(A_ST, 32'h0000_0015);
    wr(ma(10'h060), 32'h0000_0000);
    wr(A_INS, 32'h0000_6660);
    rd_chk(A_EX, 32'h0000_0200);
    rd_chk(A_ST, 32'h0000_0015);
    wr(A_INS, 32'h0001_6660);
    rd_chk(A_EX, 32'h0000_0300);
    wr(A_INS, 32'h0000_6734);
    rd_chk(A_EX, 32'h0000_0100);
    wr(A_INS, 32'h0001_6734);
    rd_chk(A_EX, 32'h0000_0100);
    // Undecoded opcode runs as a single idle cycle and leaves the flags alone
    wr(A_INS, 32'h0000_FFFF);
    rd_chk(A_EX, 32'h0000_0100);
    rd_chk(A_ST, 32'h0000_0015);
    results();
  end
endmodule

bind rotate_test_xor_exec rotate_test_xor_exec_checker u_chk (.clk, .rst_b, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout);
